// ==== core/pdam_mapper.sv ====
`timescale 1ns/100ps
// Functional notes
// - extended space paged in 32 Kbyte windows
// - visibility reads use read page only
// - page plus address gives 24-bit address
// - page zero in window raises address trap
// - pointer at free word, grows upward
// - call push clears pc top byte
// - exception push puts status low byte on top
// - limit unset at reset, bit 0 zero
// - push at limit fine, next push traps
// - pointer below 0800h raises stack trap
// - table page joins address to 24 bits
// - table page bit 7 selects configuration space
// - visibility joins page low byte with address
// - read page bit 8 selects upper word
// - visibility address bit 23 always zero
// - address bit 15 from read page bit 0
// - high table ops upper word, low lower word
// - table reads may reach configuration space
// - table writes to configuration space blocked
// - high word read upper data byte zero
module pdam_mapper (
  // clock, reset, enable
  input  wire logic                 MCLK,
  input  wire logic                 RESET,
  input  wire logic                 CLK_EN,
  // access request from the effective address unit
  input  wire pdam_pkg::pdam_acc_t  ACC_KIND,
  input  wire logic [15:0]          ACC_EA,
  input  wire logic [23:0]          PROG_RDATA,
  // stack request from the execution unit
  input  wire pdam_pkg::pdam_stk_t  STK_OP,
  input  wire logic [15:0]          STK_WDATA,
  input  wire logic [23:0]          PC_VALUE,
  // mapped outputs
  output logic [27:0]               MAP_OUT,
  output logic [15:0]               TBL_RDATA,
  output logic                      TBL_WR_BLOCKED,
  output logic [40:0]               PUSH_OUT,
  output logic [15:0]               STK_PTR,
  // trap pulses
  output logic                      ADDR_TRAP,
  output logic                      STACK_TRAP,
  // axi4-lite slave
  input  wire logic [7:0]           S_AXI_AWADDR,
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  output logic [1:0]                S_AXI_BRESP,
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  input  wire logic [7:0]           S_AXI_ARADDR,
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  output logic [31:0]               S_AXI_RDATA,
  output logic [1:0]                S_AXI_RRESP,
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY
);

  // software visible state
  logic [7:0]  tbl_page_reg;      // table_page_select
  logic [9:0]  rd_page_reg;       // data_read_page_select
  logic [9:0]  wr_page_reg;       // data_write_page_select
  logic [15:0] stk_limit_reg;     // stack_limit_value, no reset value
  logic [15:0] stk_ptr_reg;       // stack_pointer_working_reg
  logic [7:0]  srl_reg;           // status_low_byte
  logic [7:0]  addr_trap_cnt_reg; // saturating trap counters
  logic [7:0]  stk_trap_cnt_reg;

  // bus write capture
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic        wr_hit;
  logic [31:0] wr_old;            // image of the register the held write targets
  logic [31:0] wr_merged;         // that image once the strobed bytes land

  // combinational mapping results
  pdam_pkg::pdam_map_t  map_next;
  logic                 addr_trap_next;
  logic                 tbl_blocked_next;
  logic [15:0]          tbl_rdata_next;
  pdam_pkg::pdam_push_t push_next;
  logic [15:0]          ptr_next;
  logic                 stk_trap_next;

  // merge written bytes into a register image
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // write fires once both address and data are held
  assign wr_fire = aw_hold_reg && w_hold_reg && !S_AXI_BVALID;
  assign wr_hit  = (aw_addr_reg == pdam_pkg::OFS_TBL_PAGE) ||
                   (aw_addr_reg == pdam_pkg::OFS_RD_PAGE) ||
                   (aw_addr_reg == pdam_pkg::OFS_WR_PAGE) ||
                   (aw_addr_reg == pdam_pkg::OFS_STK_LIMIT) ||
                   (aw_addr_reg == pdam_pkg::OFS_STK_PTR) ||
                   (aw_addr_reg == pdam_pkg::OFS_STATUS_LOW);

  // one shared merge keeps byte strobes identical for every register
  always_comb begin
    case (aw_addr_reg)
      pdam_pkg::OFS_TBL_PAGE:   wr_old = {24'h00_0000, tbl_page_reg};
      pdam_pkg::OFS_RD_PAGE:    wr_old = {22'h00_0000, rd_page_reg};
      pdam_pkg::OFS_WR_PAGE:    wr_old = {22'h00_0000, wr_page_reg};
      pdam_pkg::OFS_STK_LIMIT:  wr_old = {16'h0000, stk_limit_reg};
      pdam_pkg::OFS_STK_PTR:    wr_old = {16'h0000, stk_ptr_reg};
      pdam_pkg::OFS_STATUS_LOW: wr_old = {24'h00_0000, srl_reg};
      default:                  wr_old = 32'h0000_0000;
    endcase
  end
  assign wr_merged = merge(wr_old, w_data_reg, w_strb_reg);

  // address and data channels taken in either order
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= pdam_pkg::RESP_OKAY;
    end else if (CLK_EN) begin
      S_AXI_AWREADY <= !aw_hold_reg && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !w_hold_reg && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        // unmapped offsets answer with a slave error
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_hit ? pdam_pkg::RESP_OKAY : pdam_pkg::RESP_SLVERR;
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // read channel, one beat answered the cycle after the address is taken
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= pdam_pkg::RESP_OKAY;
    end else if (CLK_EN) begin
      S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= pdam_pkg::RESP_OKAY;
        case (S_AXI_ARADDR)
          pdam_pkg::OFS_TBL_PAGE:   S_AXI_RDATA <= {24'h00_0000, tbl_page_reg};
          pdam_pkg::OFS_RD_PAGE:    S_AXI_RDATA <= {22'h00_0000, rd_page_reg};
          pdam_pkg::OFS_WR_PAGE:    S_AXI_RDATA <= {22'h00_0000, wr_page_reg};
          pdam_pkg::OFS_STK_LIMIT:  S_AXI_RDATA <= {16'h0000, stk_limit_reg};
          pdam_pkg::OFS_STK_PTR:    S_AXI_RDATA <= {16'h0000, stk_ptr_reg};
          pdam_pkg::OFS_STATUS_LOW: S_AXI_RDATA <= {24'h00_0000, srl_reg};
          pdam_pkg::OFS_TRAP_STAT:  S_AXI_RDATA <= {16'h0000, stk_trap_cnt_reg,
                                                    addr_trap_cnt_reg};
          default: begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= pdam_pkg::RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // page and status registers
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      tbl_page_reg <= pdam_pkg::RST_TBL_PAGE;
      rd_page_reg  <= pdam_pkg::RST_RD_PAGE;
      wr_page_reg  <= pdam_pkg::RST_WR_PAGE;
      srl_reg      <= pdam_pkg::RST_SRL;
    end else if (CLK_EN && wr_fire) begin
      case (aw_addr_reg)
        pdam_pkg::OFS_TBL_PAGE:   tbl_page_reg <= wr_merged[7:0];
        pdam_pkg::OFS_RD_PAGE:    rd_page_reg  <= wr_merged[9:0];
        pdam_pkg::OFS_WR_PAGE:    wr_page_reg  <= wr_merged[9:0];
        pdam_pkg::OFS_STATUS_LOW: srl_reg      <= wr_merged[7:0];
        default: ;
      endcase
    end
  end

  // stack limit: no reset on purpose, bit 0 always held low
  always_ff @(posedge MCLK) begin
    if (CLK_EN && wr_fire && aw_addr_reg == pdam_pkg::OFS_STK_LIMIT) begin
      stk_limit_reg <= {wr_merged[15:1], 1'b0};
    end
  end

  // address mapping for data and table accesses
  always_comb begin
    map_next         = '0;
    addr_trap_next   = 1'b0;
    tbl_blocked_next = 1'b0;
    map_next.valid   = (ACC_KIND != pdam_pkg::PDAM_ACC_NONE);
    case (ACC_KIND)
      pdam_pkg::PDAM_ACC_DREAD: begin
        if (ACC_EA[15] && rd_page_reg[pdam_pkg::RD_PAGE_PSV]) begin
          // visibility read: read page only, user space only
          map_next.prog  = 1'b1;
          map_next.upper = rd_page_reg[pdam_pkg::RD_PAGE_WSEL];
          map_next.addr  = {1'b0, rd_page_reg[7:0], ACC_EA[14:0]};
        end else if (ACC_EA[15]) begin
          // extended window, 32 Kbyte pages; page zero is the base ram
          map_next.addr  = {rd_page_reg[8:0], ACC_EA[14:0]};
          addr_trap_next = (rd_page_reg == 10'h000);
        end else begin
          map_next.addr = {8'h00, ACC_EA};
        end
      end
      pdam_pkg::PDAM_ACC_DWRITE: begin
        if (ACC_EA[15]) begin
          map_next.addr  = {wr_page_reg[8:0], ACC_EA[14:0]};
          addr_trap_next = (wr_page_reg == 10'h000);
        end else begin
          map_next.addr = {8'h00, ACC_EA};
        end
      end
      pdam_pkg::PDAM_ACC_TRDL, pdam_pkg::PDAM_ACC_TRDH,
      pdam_pkg::PDAM_ACC_TWRL, pdam_pkg::PDAM_ACC_TWRH: begin
        map_next.prog  = 1'b1;
        map_next.addr  = {tbl_page_reg, ACC_EA};
        map_next.cfg   = tbl_page_reg[pdam_pkg::TBL_CFG_BIT];
        map_next.upper = (ACC_KIND == pdam_pkg::PDAM_ACC_TRDH) ||
                         (ACC_KIND == pdam_pkg::PDAM_ACC_TWRH);
        if (map_next.cfg && (ACC_KIND == pdam_pkg::PDAM_ACC_TWRL ||
                             ACC_KIND == pdam_pkg::PDAM_ACC_TWRH)) begin
          map_next.valid   = 1'b0;
          tbl_blocked_next = 1'b1;
        end
      end
      default: ;
    endcase
  end

  // table read data: upper word carries a zero phantom byte
  always_comb begin
    tbl_rdata_next = PROG_RDATA[15:0];
    if (ACC_KIND == pdam_pkg::PDAM_ACC_TRDH) begin
      tbl_rdata_next = {8'h00, PROG_RDATA[23:16]};
    end
  end

  // stack pointer arithmetic and limit checks
  always_comb begin
    push_next     = '0;
    ptr_next      = stk_ptr_reg;
    stk_trap_next = 1'b0;
    case (STK_OP)
      pdam_pkg::PDAM_STK_PUSH, pdam_pkg::PDAM_STK_CALL, pdam_pkg::PDAM_STK_EXC: begin
        push_next.valid = 1'b1;
        push_next.addr  = stk_ptr_reg;
        ptr_next        = stk_ptr_reg + 16'h0002;
        if (STK_OP == pdam_pkg::PDAM_STK_CALL) begin
          push_next.data = {8'h00, PC_VALUE[15:0]};
        end else if (STK_OP == pdam_pkg::PDAM_STK_EXC) begin
          push_next.data = {srl_reg, PC_VALUE[15:0]};
        end else begin
          push_next.data = {8'h00, STK_WDATA};
        end
        // pushing at the limit is fine, beyond it traps
        stk_trap_next = (stk_ptr_reg > stk_limit_reg) ||
                        (stk_ptr_reg < pdam_pkg::BASE_DATA_LOW);
      end
      pdam_pkg::PDAM_STK_POP: begin
        ptr_next      = stk_ptr_reg - 16'h0002;
        stk_trap_next = (ptr_next < pdam_pkg::BASE_DATA_LOW);
      end
      pdam_pkg::PDAM_STK_IREAD: begin
        // indirect read checks only the base ram bound, never the limit
        stk_trap_next = (stk_ptr_reg < pdam_pkg::BASE_DATA_LOW);
      end
      default: ;
    endcase
  end

  // pointer register, also loadable from software
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      stk_ptr_reg <= pdam_pkg::RST_STK_PTR;
    end else if (CLK_EN) begin
      if (STK_OP != pdam_pkg::PDAM_STK_NONE) begin
        stk_ptr_reg <= ptr_next;
      end else if (wr_fire && aw_addr_reg == pdam_pkg::OFS_STK_PTR) begin
        stk_ptr_reg <= {wr_merged[15:1], 1'b0};
      end
    end
  end

  // registered outputs and trap pulses
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      MAP_OUT           <= '0;
      TBL_RDATA         <= 16'h0000;
      TBL_WR_BLOCKED    <= 1'b0;
      PUSH_OUT          <= '0;
      ADDR_TRAP         <= 1'b0;
      STACK_TRAP        <= 1'b0;
      addr_trap_cnt_reg <= 8'h00;
      stk_trap_cnt_reg  <= 8'h00;
    end else if (CLK_EN) begin
      MAP_OUT        <= map_next;
      TBL_RDATA      <= tbl_rdata_next;
      TBL_WR_BLOCKED <= tbl_blocked_next;
      PUSH_OUT       <= push_next;
      ADDR_TRAP      <= addr_trap_next;
      STACK_TRAP     <= stk_trap_next;
      if (addr_trap_next && addr_trap_cnt_reg != 8'hFF) begin
        addr_trap_cnt_reg <= addr_trap_cnt_reg + 8'h01;
      end
      if (stk_trap_next && stk_trap_cnt_reg != 8'hFF) begin
        stk_trap_cnt_reg <= stk_trap_cnt_reg + 8'h01;
      end
    end
  end

  assign STK_PTR = stk_ptr_reg;

  // checks
  a_psv_bit23: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN && ACC_KIND == pdam_pkg::PDAM_ACC_DREAD && ACC_EA[15] && rd_page_reg[9]
    |=> MAP_OUT[23] == 1'b0 && MAP_OUT[15] == $past(rd_page_reg[0]))
    else $error("visibility address bits wrong");
  a_page0_trap: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN && ACC_KIND == pdam_pkg::PDAM_ACC_DWRITE && ACC_EA[15] && wr_page_reg == 10'h000
    |=> ADDR_TRAP)
    else $error("page zero access missed trap");
  a_trap_pulse: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN && ADDR_TRAP && ACC_KIND == pdam_pkg::PDAM_ACC_NONE |=> !ADDR_TRAP)
    else $error("address trap not a pulse");
  a_push_grow: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN && STK_OP == pdam_pkg::PDAM_STK_PUSH |=> STK_PTR == $past(STK_PTR) + 16'h0002)
    else $error("push did not advance pointer");
  a_limit_equal: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN && STK_OP == pdam_pkg::PDAM_STK_PUSH && stk_ptr_reg == stk_limit_reg
    && stk_ptr_reg >= 16'h0800 |=> !STACK_TRAP)
    else $error("push at limit trapped");
  a_underflow: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN && STK_OP == pdam_pkg::PDAM_STK_IREAD && stk_ptr_reg < 16'h0800 |=> STACK_TRAP)
    else $error("underflow missed trap");
  a_call_msb: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN && STK_OP == pdam_pkg::PDAM_STK_CALL |=> PUSH_OUT[23:16] == 8'h00)
    else $error("call push msb not clear");
  a_cfg_write: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN && ACC_KIND == pdam_pkg::PDAM_ACC_TWRH && tbl_page_reg[7]
    |=> TBL_WR_BLOCKED && !MAP_OUT[27])
    else $error("config table write not blocked");
  a_phantom: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN && ACC_KIND == pdam_pkg::PDAM_ACC_TRDH |=> TBL_RDATA[15:8] == 8'h00)
    else $error("phantom byte not zero");
  c_psv_read: cover property (@(posedge MCLK) MAP_OUT[27] && MAP_OUT[26] && !MAP_OUT[25]);
  c_stack_trap: cover property (@(posedge MCLK) STACK_TRAP);
  c_addr_trap: cover property (@(posedge MCLK) ADDR_TRAP);
endmodule

// ==== core/pdam_pkg.sv ====
package pdam_pkg;
  // register map over the lite bus (byte addresses, one word each)
  localparam logic [7:0] OFS_TBL_PAGE   = 8'h00;  // table_page_select
  localparam logic [7:0] OFS_RD_PAGE    = 8'h04;  // data_read_page_select
  localparam logic [7:0] OFS_WR_PAGE    = 8'h08;  // data_write_page_select
  localparam logic [7:0] OFS_STK_LIMIT  = 8'h0C;  // stack_limit_value
  localparam logic [7:0] OFS_STK_PTR    = 8'h10;  // stack_pointer_working_reg
  localparam logic [7:0] OFS_STATUS_LOW = 8'h14;  // status_low_byte
  localparam logic [7:0] OFS_TRAP_STAT  = 8'h18;  // trap counters, read only
  // reset values
  localparam logic [7:0]  RST_TBL_PAGE  = 8'h00;
  localparam logic [9:0]  RST_RD_PAGE   = 10'h001;
  localparam logic [9:0]  RST_WR_PAGE   = 10'h001;
  localparam logic [15:0] RST_STK_PTR   = 16'h0800;
  localparam logic [7:0]  RST_SRL       = 8'h00;
  // address boundaries
  localparam logic [15:0] BASE_DATA_LOW = 16'h0800;  // bottom of base data ram
  localparam int          PAGE_BYTES    = 32768;     // extended window size
  localparam int          RD_PAGE_PSV   = 9;         // visibility enable bit
  localparam int          RD_PAGE_WSEL  = 8;         // upper/lower word select
  localparam int          TBL_CFG_BIT   = 7;         // configuration space bit
  // bus answers
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  // access kinds from the core
  typedef enum logic [2:0] {
    PDAM_ACC_NONE   = 3'b000,
    PDAM_ACC_DREAD  = 3'b001,  // data read via effective address
    PDAM_ACC_DWRITE = 3'b010,  // data write via effective address
    PDAM_ACC_TRDL   = 3'b011,  // table_read_low
    PDAM_ACC_TRDH   = 3'b100,  // table_read_high
    PDAM_ACC_TWRL   = 3'b101,  // table_write_low
    PDAM_ACC_TWRH   = 3'b110   // table_write_high
  } pdam_acc_t;

  // stack operations from the core
  typedef enum logic [2:0] {
    PDAM_STK_NONE  = 3'b000,
    PDAM_STK_PUSH  = 3'b001,  // plain word push
    PDAM_STK_POP   = 3'b010,
    PDAM_STK_CALL  = 3'b011,  // push pc, msb cleared
    PDAM_STK_EXC   = 3'b100,  // push pc with status low byte
    PDAM_STK_IREAD = 3'b101   // indirect read via pointer
  } pdam_stk_t;

  // mapped address to the memories
  typedef struct packed {
    logic        valid;
    logic        prog;      // 1: program memory, 0: data memory
    logic        cfg;       // configuration space
    logic        upper;     // upper program word
    logic [23:0] addr;
  } pdam_map_t;

  // stack push payload
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [23:0] data;
  } pdam_push_t;
endpackage

// ==== verif/pdam_core_model.sv ====
`timescale 1ns/100ps
// program memory stand-in beside the core: answers every table read
module pdam_core_model (
  // address seen by program memory
  input  wire logic [15:0] ACC_EA,
  // program word back
  output logic      [23:0] PROG_RDATA
);
  // top byte differs from the low byte so a missed phantom clear shows up
  assign PROG_RDATA = {ACC_EA[7:0] ^ 8'h3C, ACC_EA};
endmodule

// ==== verif/test_program_data_address_mapper.sv ====
`timescale 1ns/100ps
module test_program_data_address_mapper;
  // clock, reset, enable
  logic                MCLK, RESET, CLK_EN;
  // core side
  pdam_pkg::pdam_acc_t ACC_KIND;
  pdam_pkg::pdam_stk_t STK_OP;
  logic [15:0]         ACC_EA, STK_WDATA, TBL_RDATA, STK_PTR;
  logic [23:0]         PROG_RDATA, PC_VALUE;
  logic [27:0]         MAP_OUT;
  logic [40:0]         PUSH_OUT;
  logic                TBL_WR_BLOCKED, ADDR_TRAP, STACK_TRAP;
  // register bus
  logic [7:0]          S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0]         S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]          S_AXI_WSTRB;
  logic [1:0]          S_AXI_BRESP, S_AXI_RRESP;
  logic                S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic                S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic                S_AXI_RVALID, S_AXI_RREADY;
  // bookkeeping
  int                  fails, check_count;
  logic [1:0]          resp;
  logic [31:0]         rd;

  // one row: page register write, request, expected answer
  typedef struct packed {
    logic [7:0]          ofs;
    logic [31:0]         val;
    pdam_pkg::pdam_acc_t kind;
    logic [15:0]         ea;
    logic                chk_map;
    logic [27:0]         map;
    logic                trap;
    logic                blk;
  } pdam_row_t;

  localparam pdam_row_t ROWS [10] = '{
    '{8'h04, 32'h0000_0202, pdam_pkg::PDAM_ACC_DREAD, 16'h800A, 1'b1, {4'hC, 24'h01_000A}, 1'b0, 1'b0},
    '{8'h04, 32'h0000_0302, pdam_pkg::PDAM_ACC_DREAD, 16'h800A, 1'b1, {4'hD, 24'h01_000A}, 1'b0, 1'b0},
    '{8'h04, 32'h0000_0003, pdam_pkg::PDAM_ACC_DREAD, 16'h9000, 1'b1, {4'h8, 24'h01_9000}, 1'b0, 1'b0},
    '{8'h08, 32'h0000_0005, pdam_pkg::PDAM_ACC_DWRITE, 16'h9000, 1'b1, {4'h8, 24'h02_9000}, 1'b0, 1'b0},
    '{8'h04, 32'h0000_0202, pdam_pkg::PDAM_ACC_DREAD, 16'h800A, 1'b1, {4'hC, 24'h01_000A}, 1'b0, 1'b0},
    '{8'h04, 32'h0000_0000, pdam_pkg::PDAM_ACC_DREAD, 16'h8000, 1'b0, 28'h0, 1'b1, 1'b0},
    '{8'h00, 32'h0000_0085, pdam_pkg::PDAM_ACC_TRDL, 16'h1234, 1'b1, {4'hE, 24'h85_1234}, 1'b0, 1'b0},
    '{8'h00, 32'h0000_0005, pdam_pkg::PDAM_ACC_TRDH, 16'h1234, 1'b1, {4'hD, 24'h05_1234}, 1'b0, 1'b0},
    '{8'h00, 32'h0000_0005, pdam_pkg::PDAM_ACC_TWRL, 16'h1234, 1'b1, {4'hC, 24'h05_1234}, 1'b0, 1'b0},
    '{8'h00, 32'h0000_0085, pdam_pkg::PDAM_ACC_TWRH, 16'h1234, 1'b0, 28'h0, 1'b0, 1'b1}};

  pdam_mapper i_pdam_mapper (
    .MCLK(MCLK), .RESET(RESET), .CLK_EN(CLK_EN), .ACC_KIND(ACC_KIND), .ACC_EA(ACC_EA),
    .PROG_RDATA(PROG_RDATA), .STK_OP(STK_OP), .STK_WDATA(STK_WDATA), .PC_VALUE(PC_VALUE),
    .MAP_OUT(MAP_OUT), .TBL_RDATA(TBL_RDATA), .TBL_WR_BLOCKED(TBL_WR_BLOCKED),
    .PUSH_OUT(PUSH_OUT), .STK_PTR(STK_PTR), .ADDR_TRAP(ADDR_TRAP), .STACK_TRAP(STACK_TRAP),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

  pdam_core_model i_pdam_core_model (.ACC_EA(ACC_EA), .PROG_RDATA(PROG_RDATA));

  // 25 MHz core clock
  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  // one compare for every kind of value; case inequality keeps x from matching
  task automatic chk(input logic [40:0] got, input logic [40:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // single closing point for the run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // lite write: address and data offered together, each dropped on its own ready
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    S_AXI_AWADDR  <= a;
    S_AXI_WDATA   <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_BREADY  <= 1'b1;
    do begin
      @(posedge MCLK);
      if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    resp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    // one idle edge so bready is never set twice in one step
    @(posedge MCLK);
  endtask

  // lite read: rready held until the answer is sampled
  task automatic axi_rd(input logic [7:0] a);
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY  <= 1'b1;
    do begin
      @(posedge MCLK);
      if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    rd   = S_AXI_RDATA;
    resp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    @(posedge MCLK);
  endtask

  // one core request; answers land one cycle later
  task automatic req(input pdam_pkg::pdam_acc_t k, input logic [15:0] ea);
    ACC_KIND <= k;
    ACC_EA   <= ea;
    @(posedge MCLK);
    ACC_KIND <= pdam_pkg::PDAM_ACC_NONE;
    #1;
  endtask

  // one stack op; exp bit 40 low skips the push word check
  task automatic stk(input pdam_pkg::pdam_stk_t op, input logic [40:0] exp, input logic trap);
    STK_OP <= op;
    @(posedge MCLK);
    STK_OP <= pdam_pkg::PDAM_STK_NONE;
    #1;
    if (exp[40]) chk(PUSH_OUT[40:24], exp[40:24], "push addr");
    if (exp[40]) chk(PUSH_OUT[23:0], exp[23:0], "push data");
    chk(STACK_TRAP, trap, "stack trap");
    @(posedge MCLK);
    #1;
    chk(STACK_TRAP, 1'b0, "trap width");
  endtask

  // main sequence
  initial begin
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    S_AXI_WSTRB = 4'hF;
    ACC_KIND    = pdam_pkg::PDAM_ACC_NONE;
    STK_OP      = pdam_pkg::PDAM_STK_NONE;
    ACC_EA      = 16'h0000;
    STK_WDATA   = 16'h1357;
    PC_VALUE    = 24'hAB_CDEF;
    CLK_EN      = 1'b1;
    RESET       = 1'b1;
    fails       = 0;
    check_count = 0;
    repeat (12) @(posedge MCLK);
    RESET <= 1'b0;
    @(posedge MCLK);
    // unmapped places answer with an error
    axi_wr(8'h20, 32'h0000_0000);
    chk(resp, pdam_pkg::RESP_SLVERR, "unmapped write");
    axi_rd(8'h1C);
    chk(resp, pdam_pkg::RESP_SLVERR, "unmapped read");
    // ordinary mapping cases from the table
    foreach (ROWS[i]) begin
      axi_wr(ROWS[i].ofs, ROWS[i].val);
      req(ROWS[i].kind, ROWS[i].ea);
      if (ROWS[i].chk_map) chk(MAP_OUT, ROWS[i].map, "map");
      chk(ADDR_TRAP, ROWS[i].trap, "addr trap");
      chk(TBL_WR_BLOCKED, ROWS[i].blk, "cfg write blocked");
      if (ROWS[i].kind == pdam_pkg::PDAM_ACC_TRDL) chk(TBL_RDATA, ROWS[i].ea, "low");
      if (ROWS[i].kind == pdam_pkg::PDAM_ACC_TRDH)
        chk(TBL_RDATA, {8'h00, ROWS[i].ea[7:0] ^ 8'h3C}, "high");
      @(posedge MCLK);
      #1;
      chk(ADDR_TRAP, 1'b0, "addr trap width");
    end
    // a low clock enable freezes every output
    CLK_EN <= 1'b0;
    req(pdam_pkg::PDAM_ACC_TRDL, 16'h1234);
    chk(MAP_OUT, 28'h0, "frozen map");
    CLK_EN <= 1'b1;
    // limit bit 0 is dropped; no pointer read follows the limit write at once
    axi_wr(pdam_pkg::OFS_STK_LIMIT, 32'h0000_0805);
    axi_rd(pdam_pkg::OFS_STK_LIMIT);
    chk(rd[15:0], 16'h0804, "limit");
    axi_wr(pdam_pkg::OFS_STATUS_LOW, 32'h0000_005A);
    axi_wr(pdam_pkg::OFS_STK_PTR, 32'h0000_0800);
    // pushes up to the limit pass, the one past it traps
    stk(pdam_pkg::PDAM_STK_PUSH, {1'b1, 16'h0800, 24'h00_1357}, 1'b0);
    chk(STK_PTR, 16'h0802, "ptr grows");
    stk(pdam_pkg::PDAM_STK_CALL, {1'b1, 16'h0802, 24'h00_CDEF}, 1'b0);
    stk(pdam_pkg::PDAM_STK_EXC, {1'b1, 16'h0804, 24'h5A_CDEF}, 1'b0);
    stk(pdam_pkg::PDAM_STK_PUSH, 41'h0, 1'b1);
    // underflow below base ram
    axi_wr(pdam_pkg::OFS_STK_PTR, 32'h0000_0800);
    stk(pdam_pkg::PDAM_STK_POP, 41'h0, 1'b1);
    stk(pdam_pkg::PDAM_STK_IREAD, 41'h0, 1'b1);
    // reset in mid run puts the pointer back at once
    RESET <= 1'b1;
    #2;
    chk(STK_PTR, 16'h0800, "ptr reset");
    @(posedge MCLK);
    RESET <= 1'b0;
    @(posedge MCLK);
    chk(MAP_OUT, 28'h0, "map after reset");
    axi_rd(pdam_pkg::OFS_RD_PAGE);
    chk(rd, {22'h00_0000, pdam_pkg::RST_RD_PAGE}, "read page after reset");
    give_verdict();
  end

  // watchdog well past the expected run length
  initial begin
    #400000;
    fails++;
    $display("MISMATCH %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
